// ---- rtl/pat_trim_regs.sv ----
// Analogue trim and override register bank with AHB-Lite access
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// RULE1: Fine gain codes five bits, reset 8h
// RULE2: Gain code steps two percent, 8h nominal
// RULE3: Disable bit stops test-mode-4 coarse overwrite
// RULE4: Test mode 1 adds one unless disabled
// RULE5: Channel fields placed in two gain registers
// RULE6: Force bit applies stored filter tune
// RULE7: Filter tune five bits, reset 10h
// RULE8: Swing selector picks output level; 3h forbidden
// RULE9: Fallback limit three bits, reset 7h
// RULE10: Maximum step five bits, reset 7h
// RULE11: Increment three bits, reset 1h
// RULE12: Bit zero selects near-end loopback
// RULE13: Reserved sixteen-bit register, writable, reset zero
// RULE14: Reserved bits zero; writes act next edge
module pat_trim_regs
  import pat_pkg::*;
(
  input  wire logic        hclk,          // Clock, 200 MHz
  input  wire logic        hresetn,       // Async reset, low
  input  wire logic        hsel,          // Slave select
  input  wire logic [31:0] haddr,         // Byte address
  input  wire logic [1:0]  htrans,        // Transfer type
  input  wire logic        hwrite,        // Write when high
  input  wire logic [2:0]  hsize,         // Word only
  input  wire logic [31:0] hwdata,        // Write data
  input  wire logic        hready,        // Bus ready in
  output logic             hreadyout,     // Slave ready
  output logic      [31:0] hrdata,        // Read data
  output logic             hresp,         // Response
  input  wire logic        test_mode_tm1, // Chip in test mode 1
  input  wire logic        test_mode_tm4, // Chip in test mode 4
  input  wire logic [pat_pkg::PAT_COARSE_W-1:0]
                           coarse_gain_in,  // Normal coarse gain
  input  wire logic [pat_pkg::PAT_COARSE_W-1:0]
                           coarse_tm4_val,  // Test mode 4 coarse gain
  output logic [pat_pkg::PAT_COARSE_W-1:0]
                           coarse_gain_out, // Applied coarse gain
  input  wire logic [3:0][4:0] filt_auto,    // Calibrated tune A..D
  output logic      [3:0][3:0] gain_sel_out, // Fine gain A..D
  output logic      [3:0][5:0] gain_pct_out, // Percent change A..D
  output logic      [3:0][4:0] filt_tune_out,// Filter tune A..D
  output pat_pkg::pat_swing_t  swing_sel,    // Serial swing level
  output logic      [2:0]  eq_fallback_limit, // Equaliser fallbacks
  output logic      [4:0]  eq_max_step,       // Equaliser top index
  output logic      [2:0]  eq_increment,      // Equaliser step
  output logic             loopback_select,   // Near-end loopback
  output logic      [15:0] pll_reserved_out,  // Reserved trim word
  output logic      [15:0] echo_cfg_out       // Echo canceller cfg
);
  import pat_pkg::*;

  // ****************************************************************
  // Register storage and bus decode
  // ****************************************************************
  logic [15:0] gain_ab_reg;
  logic [15:0] gain_cd_reg;
  logic [15:0] tune_ab_reg;
  logic [15:0] tune_cd_reg;
  logic [15:0] pll_reg;
  logic [15:0] swing_reg;
  logic [15:0] echo_reg;
  logic [15:0] loop_reg;
  logic [15:0] rd_value;
  logic        wr_strobe;
  logic [7:0]  acc_idx;
  logic        acc_hit;
  logic [15:0] wdata;

  // Only the low half of the bus word carries register bits
  assign wdata = hwdata[15:0];

  // Address capture, read wait state and response
  pat_ahb_port u_port (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .rd_value  (rd_value),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .wr_strobe (wr_strobe),
    .acc_idx   (acc_idx),
    .acc_hit   (acc_hit)
  );

  // Write strobe for one register index
  function automatic logic wr_hit(input logic s, input logic [7:0] i,
                                  input logic [7:0] r);
    wr_hit = s && (i == r);
  endfunction : wr_hit

  // ****************************************************************
  // Transmit gain registers
  // ****************************************************************
  // Read-only reserved bits are masked off on write, so they read zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_ab_reg <= PAT_RST_GAIN; // RULE1
      gain_cd_reg <= PAT_RST_GAIN; // RULE5
    end else begin
      if (wr_hit(wr_strobe, acc_idx, PAT_IDX_GAIN_AB)) begin
        gain_ab_reg <= wdata & PAT_WM_GAIN_AB; // RULE14
      end
      if (wr_hit(wr_strobe, acc_idx, PAT_IDX_GAIN_CD)) begin
        gain_cd_reg <= wdata & PAT_WM_GAIN_CD; // RULE5
      end
    end
  end

  // ****************************************************************
  // Line driver filter tune registers
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tune_ab_reg <= PAT_RST_TUNE; // RULE7
      tune_cd_reg <= PAT_RST_TUNE; // RULE7
    end else begin
      if (wr_hit(wr_strobe, acc_idx, PAT_IDX_TUNE_AB)) begin
        tune_ab_reg <= wdata & PAT_WM_TUNE;
      end
      if (wr_hit(wr_strobe, acc_idx, PAT_IDX_TUNE_CD)) begin
        tune_cd_reg <= wdata & PAT_WM_TUNE;
      end
    end
  end

  // ****************************************************************
  // Reserved, swing, echo and loop control registers
  // ****************************************************************
  // Swing stores whatever is written; decode shields the analogue side
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pll_reg   <= PAT_RST_PLL; // RULE13
      swing_reg <= PAT_RST_SWING;
      echo_reg  <= PAT_RST_ECHO;
      loop_reg  <= PAT_RST_LOOP; // RULE9
    end else begin
      if (wr_hit(wr_strobe, acc_idx, PAT_IDX_PLL)) begin
        pll_reg <= wdata & PAT_WM_FULL; // RULE13
      end
      if (wr_hit(wr_strobe, acc_idx, PAT_IDX_SWING)) begin
        swing_reg <= wdata & PAT_WM_FULL; // RULE8
      end
      if (wr_hit(wr_strobe, acc_idx, PAT_IDX_ECHO)) begin
        echo_reg <= wdata & PAT_WM_FULL;
      end
      if (wr_hit(wr_strobe, acc_idx, PAT_IDX_LOOP)) begin
        loop_reg <= wdata & PAT_WM_LOOP; // RULE12
      end
    end
  end

  // ****************************************************************
  // Read-back multiplexer
  // ****************************************************************
  // Unmapped or misaligned addresses read zero with an OKAY response
  always_comb begin
    rd_value = 16'h0000;
    if (acc_hit) begin
      case (acc_idx)
        PAT_IDX_GAIN_AB: rd_value = gain_ab_reg;
        PAT_IDX_GAIN_CD: rd_value = gain_cd_reg;
        PAT_IDX_TUNE_AB: rd_value = tune_ab_reg;
        PAT_IDX_TUNE_CD: rd_value = tune_cd_reg;
        PAT_IDX_PLL:     rd_value = pll_reg;
        PAT_IDX_SWING:   rd_value = swing_reg;
        PAT_IDX_ECHO:    rd_value = echo_reg;
        PAT_IDX_LOOP:    rd_value = loop_reg;
        default:         rd_value = 16'h0000; // RULE14
      endcase
    end
  end

  // ****************************************************************
  // Per-channel gain and filter drive
  // ****************************************************************
  logic [3:0][4:0] lane_code;
  logic [3:0][4:0] lane_tune;
  logic [3:0]      lane_force;

  // Channel A/C in low half, B/D in high half
  assign lane_code[0] = gain_ab_reg[PAT_LO_LSB +: PAT_CODE_W];
  assign lane_code[1] = gain_ab_reg[PAT_HI_LSB +: PAT_CODE_W]; // RULE5
  assign lane_code[2] = gain_cd_reg[PAT_LO_LSB +: PAT_CODE_W]; // RULE5
  assign lane_code[3] = gain_cd_reg[PAT_HI_LSB +: PAT_CODE_W]; // RULE5
  assign lane_tune[0] = tune_ab_reg[PAT_LO_LSB +: PAT_CODE_W]; // RULE7
  assign lane_tune[1] = tune_ab_reg[PAT_HI_LSB +: PAT_CODE_W]; // RULE7
  assign lane_tune[2] = tune_cd_reg[PAT_LO_LSB +: PAT_CODE_W];
  assign lane_tune[3] = tune_cd_reg[PAT_HI_LSB +: PAT_CODE_W];
  assign lane_force[0] = tune_ab_reg[PAT_FORCE_LO]; // RULE6
  assign lane_force[1] = tune_ab_reg[PAT_FORCE_HI]; // RULE6
  assign lane_force[2] = tune_cd_reg[PAT_FORCE_LO];
  assign lane_force[3] = tune_cd_reg[PAT_FORCE_HI];

  // The test mode 1 disable lives in the AB register for all lanes
  for (genvar ch = 0; ch < 4; ch++) begin : g_lane
    pat_lane u_lane (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .gain_code  (lane_code[ch]),
      .fine_dis   (gain_ab_reg[PAT_FINE_DIS]),
      .tm1        (test_mode_tm1),
      .filt_force (lane_force[ch]),
      .filt_value (lane_tune[ch]),
      .filt_auto  (filt_auto[ch]),
      .gain_sel   (gain_sel_out[ch]),
      .gain_pct   (gain_pct_out[ch]),
      .filt_tune  (filt_tune_out[ch])
    );
  end

  // ****************************************************************
  // Coarse gain and global outputs
  // ****************************************************************
  // Test mode 4 replaces the coarse gain unless software blocks it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coarse_gain_out <= '0;
    end else if (test_mode_tm4 && !gain_ab_reg[PAT_COARSE_DIS]) begin
      coarse_gain_out <= coarse_tm4_val; // RULE3
    end else begin
      coarse_gain_out <= coarse_gain_in; // RULE3
    end
  end

  // Configuration fields drive consumers straight from the flops
  assign swing_sel = pat_swing(swing_reg[PAT_SWING_LSB +: 2]); // RULE8
  assign eq_fallback_limit = loop_reg[PAT_EQ_FB_LSB +: 3]; // RULE9
  assign eq_max_step = loop_reg[PAT_EQ_MAX_LSB +: 5]; // RULE10
  assign eq_increment = loop_reg[PAT_EQ_INC_LSB +: 3]; // RULE11
  assign loopback_select = loop_reg[PAT_LOOP_BIT]; // RULE12
  assign pll_reserved_out = pll_reg;
  assign echo_cfg_out = echo_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic rd_accept;
  logic wr_accept;
  assign rd_accept = hsel && hready && htrans == PAT_HTRANS_NONSEQ
                     && !hwrite;
  assign wr_accept = hsel && hready && htrans == PAT_HTRANS_NONSEQ
                     && hwrite;

  sequence s_read_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  sequence s_write_ab;
    wr_accept && haddr == {22'h0, PAT_IDX_GAIN_AB, 2'h0} ##1 hready;
  endsequence

  sequence s_write_loop;
    wr_accept && haddr == {22'h0, PAT_IDX_LOOP, 2'h0} ##1 hready;
  endsequence

  a_read_wait_state: assert property ( // RULE14
    rd_accept |=> s_read_wait)
    else $error("read did not take exactly one wait state");

  a_gain_ab_write: assert property ( // RULE14
    s_write_ab |=> gain_ab_reg == ($past(hwdata[15:0]) & PAT_WM_GAIN_AB))
    else $error("gain AB register did not take written value");

  a_loop_write: assert property ( // RULE12
    s_write_loop |=> loopback_select == $past(hwdata[0])
                     && loop_reg[4:1] == 4'h0)
    else $error("loop control write not applied");

  a_gain_cd_rsvd: assert property ( // RULE14
    gain_cd_reg[15:13] == 3'h0 && gain_cd_reg[7:5] == 3'h0)
    else $error("reserved gain bits not zero");

  a_fine_plus_one: assert property ( // RULE4
    test_mode_tm1 && !gain_ab_reg[PAT_FINE_DIS]
    && gain_ab_reg[11:8] < 4'hf
    |=> gain_sel_out[1] == $past(gain_ab_reg[11:8]) + 4'h1)
    else $error("test mode 1 did not add one to fine gain");

  a_fine_plain: assert property ( // RULE1
    !test_mode_tm1 |=> gain_sel_out[1] == $past(gain_ab_reg[11:8]))
    else $error("fine gain not passed through");

  a_gain_percent: assert property ( // RULE2
    $signed(gain_pct_out[2]) == 2 * $signed({1'b0, gain_sel_out[2]}) - 16)
    else $error("gain percent does not match code");

  a_coarse_block: assert property ( // RULE3
    test_mode_tm4 && gain_ab_reg[PAT_COARSE_DIS]
    |=> coarse_gain_out == $past(coarse_gain_in))
    else $error("coarse overwrite not suppressed");

  a_filter_force: assert property ( // RULE6
    tune_cd_reg[PAT_FORCE_HI] |=> filt_tune_out[3] == $past(tune_cd_reg[12:8]))
    else $error("forced filter tune not applied");

  a_filter_auto: assert property ( // RULE6
    !tune_ab_reg[PAT_FORCE_LO] |=> filt_tune_out[0] == $past(filt_auto[0]))
    else $error("unforced filter tune not from calibration");

  a_reset_fields: assert property ( // RULE10
    $rose(hresetn) |-> eq_max_step == 5'h07 && eq_increment == 3'h1
                       && eq_fallback_limit == 3'h7
                       && tune_ab_reg == 16'h1010 && pll_reg == 16'h0)
    else $error("fields not at reset values");

  a_swing_forbidden: assert property ( // RULE8
    swing_reg[14:13] == 2'h3 |-> swing_sel == PAT_SWING_1100)
    else $error("forbidden swing code not held at default");

endmodule : pat_trim_regs

// ---- rtl/pat_pkg.sv ----
// Shared constants, types and helpers for the analogue trim register bank
package pat_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] PAT_IDX_GAIN_AB = 8'ha0;
  localparam logic [7:0] PAT_IDX_GAIN_CD = 8'ha1;
  localparam logic [7:0] PAT_IDX_TUNE_AB = 8'ha2;
  localparam logic [7:0] PAT_IDX_TUNE_CD = 8'ha3;
  localparam logic [7:0] PAT_IDX_PLL     = 8'hc6;
  localparam logic [7:0] PAT_IDX_SWING   = 8'hd6;
  localparam logic [7:0] PAT_IDX_ECHO    = 8'he9;
  localparam logic [7:0] PAT_IDX_LOOP    = 8'hfe;

  // ****************************************************************
  // Reset values and writable-bit masks
  // ****************************************************************
  localparam logic [15:0] PAT_RST_GAIN  = 16'h0808;
  localparam logic [15:0] PAT_RST_TUNE  = 16'h1010;
  localparam logic [15:0] PAT_RST_PLL   = 16'h0000;
  localparam logic [15:0] PAT_RST_SWING = 16'h0000;
  localparam logic [15:0] PAT_RST_ECHO  = 16'h9f22;
  localparam logic [15:0] PAT_RST_LOOP  = 16'he720;
  localparam logic [15:0] PAT_WM_GAIN_AB = 16'hdf1f;
  localparam logic [15:0] PAT_WM_GAIN_CD = 16'h1f1f;
  localparam logic [15:0] PAT_WM_TUNE    = 16'h3f3f;
  localparam logic [15:0] PAT_WM_FULL    = 16'hffff;
  localparam logic [15:0] PAT_WM_LOOP    = 16'hffe1;

  // ****************************************************************
  // Field positions and widths
  // ****************************************************************
  localparam int PAT_CODE_W      = 5;
  localparam int PAT_HI_LSB      = 8;
  localparam int PAT_LO_LSB      = 0;
  localparam int PAT_COARSE_DIS  = 15;
  localparam int PAT_FINE_DIS    = 14;
  localparam int PAT_FORCE_HI    = 13;
  localparam int PAT_FORCE_LO    = 5;
  localparam int PAT_SWING_LSB   = 13;
  localparam int PAT_EQ_FB_LSB   = 13;
  localparam int PAT_EQ_MAX_LSB  = 8;
  localparam int PAT_EQ_INC_LSB  = 5;
  localparam int PAT_LOOP_BIT    = 0;
  localparam int PAT_COARSE_W    = 3;
  localparam logic [3:0] PAT_RST_GSEL = 4'h8;
  localparam logic [4:0] PAT_RST_LPF  = 5'h10;
  localparam logic [1:0] PAT_HTRANS_NONSEQ = 2'b10;

  // Bus port phases and swing choices
  typedef enum logic [1:0] {PAT_IDLE, PAT_WRITE, PAT_RD_WAIT,
                            PAT_RD_DONE} pat_bus_state_t;
  typedef enum logic [1:0] {PAT_SWING_1100, PAT_SWING_1280,
                            PAT_SWING_0920} pat_swing_t;

  // Gain change in percent: two per step, code 8 is nominal
  function automatic logic [5:0] pat_gain_pct(input logic [3:0] c);
    pat_gain_pct = 6'({1'b0, c, 1'b0}) - 6'h10;
  endfunction : pat_gain_pct

  // Swing decode; the forbidden code falls back to the default level
  function automatic pat_swing_t pat_swing(input logic [1:0] s);
    case (s)
      2'h1:    pat_swing = PAT_SWING_1280;
      2'h2:    pat_swing = PAT_SWING_0920;
      default: pat_swing = PAT_SWING_1100;
    endcase
  endfunction : pat_swing

endpackage : pat_pkg

// ---- rtl/pat_lane.sv ----
// One transmit channel: fine gain override and filter tune selection
`timescale 1ns/1ps
module pat_lane
  import pat_pkg::*;
(
  input  wire logic       hclk,        // Register clock
  input  wire logic       hresetn,     // Async reset, low
  input  wire logic [4:0] gain_code,   // Stored fine gain code
  input  wire logic       fine_dis,    // Fine override disable
  input  wire logic       tm1,         // Chip in test mode 1
  input  wire logic       filt_force,  // Tune force bit
  input  wire logic [4:0] filt_value,  // Stored tune value
  input  wire logic [4:0] filt_auto,   // Tune from calibration
  output logic      [3:0] gain_sel,    // Applied fine gain
  output logic      [5:0] gain_pct,    // Signed percent change
  output logic      [4:0] filt_tune    // Applied filter tune
);
  logic [3:0] code_next;

  // Top bit of the code is ignored; test mode 1 adds one, saturating
  always_comb begin
    code_next = gain_code[3:0];
    if (tm1 && !fine_dis && gain_code[3:0] != 4'hf) begin
      code_next = gain_code[3:0] + 4'h1; // RULE4
    end
  end

  // Gain outputs follow from the next edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gain_sel <= PAT_RST_GSEL;
      gain_pct <= 6'h00;
    end else begin
      gain_sel <= code_next; // RULE1
      gain_pct <= pat_gain_pct(code_next); // RULE2
    end
  end

  // Force bit picks the stored value over calibration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_tune <= PAT_RST_LPF;
    end else begin
      filt_tune <= filt_force ? filt_value : filt_auto; // RULE6
    end
  end
endmodule : pat_lane

// ---- rtl/pat_ahb_port.sv ----
// AHB-Lite slave front end: address capture, wait state, read data
`timescale 1ns/1ps
module pat_ahb_port
  import pat_pkg::*;
(
  input  wire logic        hclk,       // Bus clock
  input  wire logic        hresetn,    // Async reset, low
  input  wire logic        hsel,       // Slave select
  input  wire logic [31:0] haddr,      // Byte address
  input  wire logic [1:0]  htrans,     // Transfer type
  input  wire logic        hwrite,     // Write when high
  input  wire logic        hready,     // Bus ready in
  input  wire logic [15:0] rd_value,   // Decoded read word
  output logic             hreadyout,  // Slave ready out
  output logic      [31:0] hrdata,     // Read data
  output logic             hresp,      // Always OKAY
  output logic             wr_strobe,  // Write data phase
  output logic      [7:0]  acc_idx,    // Register index
  output logic             acc_hit     // Address is aligned, in range
);
  pat_bus_state_t state_reg;
  pat_bus_state_t state_next;
  logic           accept;

  assign accept = hsel && hready && htrans[1];
  assign hresp = 1'b0;
  assign hreadyout = (state_reg != PAT_RD_WAIT);
  assign wr_strobe = (state_reg == PAT_WRITE) && acc_hit;

  // Reads take one wait state so that hrdata comes from a flop
  always_comb begin
    state_next = PAT_IDLE;
    case (state_reg)
      PAT_RD_WAIT: state_next = PAT_RD_DONE;
      default: begin
        if (accept) begin
          state_next = hwrite ? PAT_WRITE : PAT_RD_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= PAT_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_idx <= 8'h00;
      acc_hit <= 1'b0;
    end else if (accept) begin
      acc_idx <= haddr[9:2];
      acc_hit <= (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    end
  end

  // Read word registered during the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (state_reg == PAT_RD_WAIT) begin
      hrdata <= {16'h0000, rd_value};
    end
  end
endmodule : pat_ahb_port

// ---- sim/pat_trim_regs_test.sv ----
// Self-checking bench for the analogue trim register bank
`timescale 1ns/1ps
module pat_trim_regs_test;
  import pat_pkg::*;
  logic            hclk = 1'b0;
  logic            hresetn = 1'b0;
  logic            hsel, hwrite, hready, hreadyout, hresp;
  logic            test_mode_tm1, test_mode_tm4, loopback_select;
  logic [1:0]      htrans;
  logic [2:0]      hsize, coarse_gain_in, coarse_tm4_val, coarse_gain_out;
  logic [2:0]      eq_fallback_limit, eq_increment;
  logic [4:0]      eq_max_step;
  logic [3:0]      c;
  logic [15:0]     pll_reserved_out, echo_cfg_out, v;
  logic [31:0]     haddr, hwdata, hrdata, rv;
  logic [3:0][4:0] filt_auto, filt_tune_out;
  logic [3:0][3:0] gain_sel_out;
  logic [3:0][5:0] gain_pct_out;
  pat_swing_t      swing_sel;
  int              err_count = 0;
  int              check_count = 0;
  int              cycles = 0;
  // Register table: index, reset word, writable bits
  localparam logic [7:0] IDX [8] = '{PAT_IDX_GAIN_AB, PAT_IDX_GAIN_CD,
    PAT_IDX_TUNE_AB, PAT_IDX_TUNE_CD, PAT_IDX_PLL, PAT_IDX_SWING,
    PAT_IDX_ECHO, PAT_IDX_LOOP};
  localparam logic [15:0] RST [8] = '{16'h0808, 16'h0808, 16'h1010,
    16'h1010, 16'h0000, 16'h0000, 16'h9f22, 16'he720};
  localparam logic [15:0] MSK [8] = '{16'hdf1f, 16'h1f1f, 16'h3f3f,
    16'h3f3f, 16'hffff, 16'hffff, 16'hffff, 16'hffe1};
  localparam logic [3:0] CODES [5] = '{4'h0, 4'h1, 4'h8, 4'h9, 4'hf};
  localparam logic [5:0] PCT [5] = '{6'h30, 6'h32, 6'h00, 6'h02, 6'h0e};

  always #2.5 hclk = ~hclk;
  assign hready = hreadyout; // Single slave drives the bus ready

  pat_trim_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .test_mode_tm1(test_mode_tm1),
    .test_mode_tm4(test_mode_tm4), .coarse_gain_in(coarse_gain_in),
    .coarse_tm4_val(coarse_tm4_val), .coarse_gain_out(coarse_gain_out),
    .filt_auto(filt_auto), .gain_sel_out(gain_sel_out),
    .gain_pct_out(gain_pct_out), .filt_tune_out(filt_tune_out),
    .swing_sel(swing_sel), .eq_fallback_limit(eq_fallback_limit),
    .eq_max_step(eq_max_step), .eq_increment(eq_increment),
    .loopback_select(loopback_select),
    .pll_reserved_out(pll_reserved_out), .echo_cfg_out(echo_cfg_out));

  function automatic logic [31:0] adr(input logic [7:0] i);
    adr = {22'h0, i, 2'b00};
  endfunction : adr

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Ready is sampled at the rising edge; each phase holds until then
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [15:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= PAT_HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic rd(input string what, input logic [31:0] a,
                    input logic [15:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 16'h0, q);
    chk(what, q, {16'h0, exp});
  endtask : rd

  // Lane outputs trail the register by one more edge
  task automatic settle;
    @(posedge hclk);
    @(negedge hclk);
  endtask : settle

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      err_count++;
      results();
    end
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, test_mode_tm1} = '0;
    hsize = 3'h2;
    test_mode_tm4 = 1'b1;
    coarse_gain_in = 3'h2;
    coarse_tm4_val = 3'h5;
    filt_auto = {5'h04, 5'h03, 5'h02, 5'h01};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    for (int i = 0; i < 4; i++) begin
      chk("gain_sel", gain_sel_out[i], 4'h8);
      chk("gain_pct", gain_pct_out[i], 6'h00);
      chk("filt_tune", filt_tune_out[i], filt_auto[i]);
    end
    chk("coarse tm4", coarse_gain_out, 3'h5);
    chk("eq", {eq_fallback_limit, eq_max_step, eq_increment,
        loopback_select}, 12'he72);
    chk("swing", swing_sel, 2'h0);
    chk("pll", pll_reserved_out, 16'h0);
    for (int i = 0; i < 8; i++) rd("reset", adr(IDX[i]), RST[i]);
    $display("test reset done");
    // All ones; swing code kept off the forbidden value
    for (int i = 0; i < 8; i++) begin
      v = (i == 5) ? 16'hbfff : 16'hffff;
      xfer(1'b1, adr(IDX[i]), v, rv);
      rd("mask", adr(IDX[i]), v & MSK[i]);
    end
    settle();
    chk("coarse kept", coarse_gain_out, 3'h2);
    chk("fine ones", gain_sel_out, {4{4'hf}});
    chk("forced tune", filt_tune_out, {4{5'h1f}});
    chk("swing one", swing_sel, 2'h1);
    chk("echo", echo_cfg_out, 16'hffff);
    $display("test masks done");
    for (int k = 0; k < 5; k++) begin
      c = CODES[k];
      xfer(1'b1, adr(PAT_IDX_GAIN_AB), {4'h1, c ^ 4'h1, 4'h1, c}, rv);
      xfer(1'b1, adr(PAT_IDX_GAIN_CD), {4'h0, c ^ 4'h3, 4'h0, c ^ 4'h2},
           rv);
      settle();
      for (int j = 0; j < 4; j++)
        chk("gain code", gain_sel_out[j], c ^ 4'(j));
      chk("gain pct", gain_pct_out[0], PCT[k]);
    end
    $display("test gain codes done");
    @(posedge hclk);
    test_mode_tm1 <= 1'b1;
    settle();
    chk("tm1 plus", gain_sel_out, 16'hdeff);
    chk("coarse tm4", coarse_gain_out, 3'h5);
    xfer(1'b1, adr(PAT_IDX_GAIN_AB), 16'h4e0f, rv);
    settle();
    chk("tm1 off", gain_sel_out, 16'hcdef);
    @(posedge hclk);
    test_mode_tm1 <= 1'b0;
    $display("test mode one done");
    xfer(1'b1, adr(PAT_IDX_TUNE_AB), 16'h2b0a, rv);
    xfer(1'b1, adr(PAT_IDX_TUNE_CD), 16'h0025, rv);
    settle();
    chk("tune", filt_tune_out, {5'h04, 5'h05, 5'h0b, 5'h01});
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, adr(PAT_IDX_SWING), {1'b0, 2'(k), 13'h0}, rv);
      settle();
      chk("swing code", swing_sel, 32'(k));
    end
    xfer(1'b1, adr(PAT_IDX_LOOP), 16'h4aa1, rv);
    settle();
    chk("eq set", {eq_fallback_limit, eq_max_step, eq_increment,
        loopback_select}, 12'h4ab);
    xfer(1'b1, adr(PAT_IDX_PLL), 16'ha5c3, rv);
    rd("pll", adr(PAT_IDX_PLL), 16'ha5c3);
    $display("test fields done");
    xfer(1'b1, 32'h0000_0281, 16'h1234, rv);
    rd("unmapped", 32'h0000_0400, 16'h0);
    rd("misaligned", 32'h0000_0281, 16'h0);
    rd("gain kept", adr(PAT_IDX_GAIN_AB), 16'h4e0f);
    chk("hresp", hresp, 1'b0);
    $display("test unmapped done");
    results();
  end
endmodule : pat_trim_regs_test
